// ---- src/sts_regs.vh ----
// constants and timing counts for the self-test supervisor
`ifndef STS_REGS_VH
`define STS_REGS_VH
`define STS_CLK_HZ 50000000
`define STS_OFS_WARN_MV 16'h0032
`define STS_OFS_FAIL_MV 16'h004B
`define STS_PULSE_MS 1000
`define STS_PULSE_CYC ((`STS_CLK_HZ / 1000) * `STS_PULSE_MS)
`define STS_CONV_MAX_US 100
`define STS_CONV_MAX_CYC ((`STS_CLK_HZ / 1000000) * `STS_CONV_MAX_US)
`define STS_ST_OK 2'h0
`define STS_ST_WARN 2'h1
`define STS_ST_FAIL 2'h2
`endif

// ---- src/sts_offset_check.v ----
// offset level classifier for one offset source
`include "sts_regs.vh"
module sts_offset_check (
  clk,
  reset,
  sample_valid,
  offset_mv,
  state_reg
);
  input wire clk;
  input wire reset;
  input wire sample_valid; // new magnitude present
  input wire [15:0] offset_mv; // offset magnitude in millivolts
  output reg [1:0] state_reg; // ok / warn / fail

  // classify each sample; state holds until the next sample
  always @(posedge clk) begin
    if (reset) begin
      state_reg <= `STS_ST_OK;
    end else if (sample_valid) begin
      if (offset_mv > `STS_OFS_FAIL_MV) begin
        state_reg <= `STS_ST_FAIL;
      end else if (offset_mv > `STS_OFS_WARN_MV) begin
        state_reg <= `STS_ST_WARN;
      end else begin
        state_reg <= `STS_ST_OK;
      end
    end
  end
endmodule

// ---- src/sts_supervisor.v ----
// self-test supervisor deriving disables, alarm and status report
`include "sts_regs.vh"
module sts_supervisor #(
  parameter PULSE_CYC = `STS_PULSE_CYC,
  parameter CONV_MAX_CYC = `STS_CONV_MAX_CYC
) (
  clk,
  reset,
  conv_start,
  conv_done,
  master_offset_valid,
  master_offset_mv,
  chan_offset_valid,
  chan_offset_mv,
  settings_cmp,
  settings_img_a,
  settings_img_b,
  mem_rw_fail,
  mem_sum_fail,
  logic_supply_fail,
  analog_supply_fail,
  protection_disable,
  control_disable,
  output_block,
  alarm_contact,
  status_report,
  test_state
);
  input wire clk;
  input wire reset;
  input wire conv_start; // converter start pulse
  input wire conv_done; // converter end pulse
  input wire master_offset_valid; // grounded input sample ready
  input wire [15:0] master_offset_mv;
  input wire chan_offset_valid; // worst channel sample ready
  input wire [15:0] chan_offset_mv;
  input wire settings_cmp; // compare request pulse
  input wire [31:0] settings_img_a; // first stored image word
  input wire [31:0] settings_img_b; // second stored image word
  input wire mem_rw_fail; // memory read-write check failed
  input wire mem_sum_fail; // stored checksum mismatch
  input wire logic_supply_fail; // logic supply beyond limits
  input wire analog_supply_fail; // analog supply beyond limits
  output reg protection_disable;
  output reg control_disable;
  output reg output_block; // all output relays de-energized
  output wire alarm_contact;
  output reg status_report; // one-cycle report request
  output wire [15:0] test_state; // packed test states

  // converter watchdog
  reg conv_busy_reg;
  reg [31:0] conv_cnt_reg;
  reg conv_fail_reg; // sticky: no warning level
  // settings compare
  reg set_fail_reg;
  // other sticky failures
  reg mem_fail_reg;
  reg lsup_fail_reg;
  reg asup_fail_reg;
  // alarm latch and pulse timer
  reg alarm_latch_reg;
  reg [31:0] pulse_cnt_reg;
  reg [15:0] prev_state_reg;
  wire [1:0] mof_state; // master_offset_check state
  wire [1:0] chan_state;
  reg [1:0] mof_prev_reg;
  reg [1:0] chan_prev_reg;
  wire mof_fail_rise;
  wire chan_fail_rise;
  wire [15:0] state_now;

  // how the pieces fit together:
  // - every failure source but the two offsets ends in a sticky flag, so a transient
  //   fault still leaves the relay in its safe state until reset
  // - the offset sources are the only ones with a warning level;
  //   their state follows the latest sample and may return to ok
  // - warnings only ever reach the status report, never the
  //   disables or the alarm contact
  // - the alarm contact has two causes: a permanent latch for the
  //   sticky failures and a one-shot pulse for offset failures
  // - all gating outputs are registered so that a glitch on a
  //   failure input can never chatter a protection element
  // limitation: nothing but reset clears a sticky failure; a field unit
  // would re-run its self-tests after a restart to come back up

  sts_offset_check u_master_offset_check (
    .clk(clk),
    .reset(reset),
    .sample_valid(master_offset_valid),
    .offset_mv(master_offset_mv),
    .state_reg(mof_state)
  );

  sts_offset_check u_chan_offset_check (
    .clk(clk),
    .reset(reset),
    .sample_valid(chan_offset_valid),
    .offset_mv(chan_offset_mv),
    .state_reg(chan_state)
  );

  // conversion timing: too long or never done both end here
  // the counter only runs while a conversion is outstanding, so an
  // idle converter never trips the watchdog; a done pulse in the
  // same cycle as a start wins, as the converter has just finished
  always @(posedge clk) begin
    if (reset) begin
      conv_busy_reg <= 1'b0;
      conv_cnt_reg <= 32'h00000000;
      conv_fail_reg <= 1'b0;
    end else begin
      if (conv_done) begin
        conv_busy_reg <= 1'b0;
        conv_cnt_reg <= 32'h00000000;
      end else if (conv_start) begin
        conv_busy_reg <= 1'b1;
        conv_cnt_reg <= 32'h00000000;
      end else if (conv_busy_reg) begin
        conv_cnt_reg <= conv_cnt_reg + 32'h00000001;
      end
      // a stuck conversion trips the same limit as a slow one
      if (conv_busy_reg && !conv_done &&
          conv_cnt_reg >= CONV_MAX_CYC - 1) begin
        conv_fail_reg <= 1'b1;
      end
    end
  end

  // sticky failures; only reset clears them, as a relay would
  always @(posedge clk) begin
    if (reset) begin
      set_fail_reg <= 1'b0;
      mem_fail_reg <= 1'b0;
      lsup_fail_reg <= 1'b0;
      asup_fail_reg <= 1'b0;
    end else begin
      if (settings_cmp && settings_img_a != settings_img_b) begin
        set_fail_reg <= 1'b1;
      end
      if (mem_rw_fail || mem_sum_fail) begin
        mem_fail_reg <= 1'b1;
      end
      if (logic_supply_fail) begin
        lsup_fail_reg <= 1'b1;
      end
      if (analog_supply_fail) begin
        asup_fail_reg <= 1'b1;
      end
    end
  end

  assign mof_fail_rise = (mof_state == `STS_ST_FAIL) &&
                         (mof_prev_reg != `STS_ST_FAIL);
  assign chan_fail_rise = (chan_state == `STS_ST_FAIL) &&
                          (chan_prev_reg != `STS_ST_FAIL);

  // alarm: permanent latch plus one-shot pulse, warnings excluded
  // the pulse fires on the edge into failure only, so an offset that
  // stays failed does not keep the contact closed; trade-off: a
  // source that toggles between warn and fail pulses every time
  always @(posedge clk) begin
    if (reset) begin
      alarm_latch_reg <= 1'b0;
      pulse_cnt_reg <= 32'h00000000;
      mof_prev_reg <= `STS_ST_OK;
      chan_prev_reg <= `STS_ST_OK;
    end else begin
      mof_prev_reg <= mof_state;
      chan_prev_reg <= chan_state;
      if (conv_fail_reg || set_fail_reg || mem_fail_reg ||
          lsup_fail_reg || asup_fail_reg) begin
        alarm_latch_reg <= 1'b1;
      end
      // a new offset failure restarts the full pulse
      if (mof_fail_rise || chan_fail_rise) begin
        pulse_cnt_reg <= PULSE_CYC;
      end else if (pulse_cnt_reg != 32'h00000000) begin
        pulse_cnt_reg <= pulse_cnt_reg - 32'h00000001;
      end
    end
  end

  assign alarm_contact = alarm_latch_reg ||
                         (pulse_cnt_reg != 32'h00000000);

  // packed states: conv, settings, mem, lsup, asup, mof, chan
  assign state_now = {5'h00,
                      conv_fail_reg, set_fail_reg, mem_fail_reg,
                      lsup_fail_reg, asup_fail_reg,
                      2'h0, mof_state, chan_state};
  assign test_state = prev_state_reg;

  // gating outputs and status report on any state change
  // the report compares the live state with the registered copy, so
  // it rises in the same cycle as test_state shows the new value
  // hazard: two changes in back-to-back cycles give two reports,
  // which the report consumer must be able to take
  always @(posedge clk) begin
    if (reset) begin
      protection_disable <= 1'b0;
      control_disable <= 1'b0;
      output_block <= 1'b0;
      status_report <= 1'b0;
      prev_state_reg <= 16'h0000;
    end else begin
      // offsets never gate protection or control
      protection_disable <= conv_fail_reg || set_fail_reg ||
                            mem_fail_reg || lsup_fail_reg ||
                            asup_fail_reg;
      control_disable <= set_fail_reg || mem_fail_reg ||
                         lsup_fail_reg;
      output_block <= lsup_fail_reg;
      prev_state_reg <= state_now;
      status_report <= (state_now != prev_state_reg);
    end
  end
endmodule

// ---- sim/sts_sup_assertions.sv ----
// port-level checks for the self-test supervisor
module sts_sup_assertions #(parameter int PULSE_CYC = 20) (
  input wire clk, reset, conv_start, conv_done, settings_cmp,
  input wire [31:0] settings_img_a, settings_img_b,
  input wire mem_rw_fail, mem_sum_fail, logic_supply_fail,
  input wire analog_supply_fail, protection_disable, control_disable,
  input wire output_block, alarm_contact, status_report,
  input wire [15:0] test_state
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P_END = PULSE_CYC - 7; // alarm low right after the pulse
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire latched = |test_state[10:6]; // any sticky failure flag
  a_lsup_blocks: assert property (logic_supply_fail |-> ##2
    output_block && control_disable && alarm_contact) else $error("lsup");
  a_asup_prot: assert property (analog_supply_fail |-> ##2
    protection_disable && alarm_contact) else $error("asup");
  a_mem_all: assert property (mem_rw_fail || mem_sum_fail |-> ##2
    protection_disable && control_disable && alarm_contact) else $error("mem");
  a_set_fail: assert property (settings_cmp &&
    settings_img_a != settings_img_b |-> ##2 test_state[9] &&
    control_disable && protection_disable) else $error("settings");
  a_ctl_cause: assert property (control_disable |->
    |test_state[9:7]) else $error("control off without cause");
  a_prot_cause: assert property (protection_disable |->
    latched) else $error("protection off without cause");
  a_conv_stuck: assert property (conv_start ##1
    (!conv_done && !conv_start) [*8] ##1 (!conv_done && !conv_start) [*6]
    |-> ##[0:4] test_state[10] && protection_disable) else $error("conv");
  a_pulse_len: assert property ($rose(alarm_contact) && !latched
    |-> alarm_contact [*8] ##P_END !alarm_contact) else $error("pulse");
  a_report_chg: assert property ($changed(test_state) |->
    status_report) else $error("no report");
  c_pulse: cover property ($rose(alarm_contact) && !latched);
  c_block: cover property (output_block);
  c_report: cover property (status_report);
endmodule
bind sts_supervisor sts_sup_assertions #(.PULSE_CYC(PULSE_CYC)) u_chk (
  .clk, .reset, .conv_start, .conv_done, .settings_cmp, .settings_img_a,
  .settings_img_b, .mem_rw_fail, .mem_sum_fail, .logic_supply_fail,
  .analog_supply_fail, .protection_disable, .control_disable,
  .output_block, .alarm_contact, .status_report, .test_state);

// ---- sim/sts_relay_model.sv ----
// far-side relay output stage gated by the supervisor
module sts_relay_model (
  input wire clk, protection_disable, control_disable, output_block,
  output logic prot_live, ctl_live
);
  timeunit 1ns;
  timeprecision 1ps;
  // a blocked driver port stops every element, whatever else says
  always @(posedge clk) begin
    prot_live <= !protection_disable && !output_block;
    ctl_live <= !control_disable && !output_block;
  end
endmodule

// ---- sim/tb.sv ----
// self-checking bench for the self-test supervisor
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, conv_start = 0, conv_done = 0, settings_cmp = 0;
  logic master_offset_valid = 0, chan_offset_valid = 0;
  logic [15:0] master_offset_mv = 0, chan_offset_mv = 0;
  logic [31:0] settings_img_a = 32'h12345678, settings_img_b = 32'h12345678;
  logic [3:0] fl = 0; // mem rw, mem sum, logic supply, analog supply
  wire protection_disable, control_disable, output_block, alarm_contact;
  wire status_report, prot_live, ctl_live;
  wire [15:0] test_state;
  int error_cnt = 0, n_compared = 0, rep_cnt = 0, cyc = 0, r;
  sts_supervisor #(.PULSE_CYC(20), .CONV_MAX_CYC(10)) uut (.clk, .reset,
    .conv_start, .conv_done, .master_offset_valid, .master_offset_mv,
    .chan_offset_valid, .chan_offset_mv, .settings_cmp, .settings_img_a,
    .settings_img_b, .mem_rw_fail(fl[3]), .mem_sum_fail(fl[2]),
    .logic_supply_fail(fl[1]), .analog_supply_fail(fl[0]),
    .protection_disable, .control_disable, .output_block, .alarm_contact,
    .status_report, .test_state);
  sts_relay_model relay (.clk, .protection_disable, .control_disable,
    .output_block, .prot_live, .ctl_live);
  always #10 clk = ~clk;
  // report counter and hang guard
  always @(posedge clk) begin
    if (status_report === 1'b1) rep_cnt <= rep_cnt + 1;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      stop_test;
    end
  end
  task automatic stop_test;
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rst;
    reset = 1; fl = 0; tick(2); reset = 0; tick(1);
  endtask
  // one offset sample on the master (ch=0) or channel (ch=1) source
  task automatic ofs(input logic ch, input logic [15:0] v);
    master_offset_mv = v; chan_offset_mv = v;
    master_offset_valid = !ch; chan_offset_valid = ch;
    tick(1); master_offset_valid = 0; chan_offset_valid = 0; tick(4);
  endtask
  task automatic cmp(input logic [31:0] b);
    settings_img_b = b; settings_cmp = 1; tick(1); settings_cmp = 0; tick(4);
  endtask
  initial begin
    tick(16); reset = 0; tick(1);
    for (int c = 0; c < 2; c++) begin
      ofs(c, 16'h0032); chk(test_state, 16'h0000);
      r = rep_cnt;
      ofs(c, 16'h004B); chk(test_state, c ? 16'h0001 : 16'h0004);
      chk(alarm_contact, 0);
      ofs(c, 16'h004C); chk(test_state, c ? 16'h0002 : 16'h0008);
      chk(16'(rep_cnt - r), 2);
      chk({alarm_contact, protection_disable, control_disable}, 4);
      tick(20); chk(alarm_contact, 0);
      ofs(c, 16'h0000);
    end
    conv_start = 1; tick(1); conv_start = 0; tick(3);
    conv_done = 1; tick(1); conv_done = 0; tick(15);
    chk(test_state, 16'h0000);
    conv_start = 1; tick(1); conv_start = 0; tick(16);
    chk({test_state[10], protection_disable, control_disable,
      alarm_contact}, 16'hD);
    chk({prot_live, ctl_live}, 1);
    rst; cmp(32'h12345678); chk(control_disable, 0);
    cmp(32'h12345679); chk({test_state[9], protection_disable,
      control_disable, alarm_contact}, 16'hF);
    for (int i = 0; i < 4; i++) begin
      rst; fl = 4'h8 >> i; tick(4);
      chk({protection_disable, control_disable, output_block, alarm_contact},
        {1'b1, i < 3, i == 2, 1'b1});
      chk(test_state[10:6], i < 2 ? 16'h4 : 16'h1 << (3 - i));
    end
    stop_test;
  end
endmodule
